// file: include/psrw_regs.vh
// register offsets, field positions and reset values of the readback register bank
`ifndef PSRW_REGS_VH
`define PSRW_REGS_VH

// ****************************************************************
// byte offsets on the register bus
// ****************************************************************
`define PSRW_AW 6
`define PSRW_OFS_SYSCTL 6'h00
`define PSRW_OFS_CHCTL0 6'h04
`define PSRW_OFS_CHRB0 6'h14
`define PSRW_OFS_CMPRB 6'h24
`define PSRW_OFS_IRQSTAT 6'h28
`define PSRW_OFS_IRQMASK 6'h2C

// ****************************************************************
// control field positions (system and per-channel control)
// ****************************************************************
`define PSRW_CB_CLAMP 0
`define PSRW_CB_DRV 1
`define PSRW_CB_CMPV 2
`define PSRW_CB_CLR 3

// ****************************************************************
// readback word field positions
// ****************************************************************
`define PSRW_RB_KIND_HI 23
`define PSRW_RB_KIND_LO 22
`define PSRW_RB_CLAMP 9
`define PSRW_RB_DRV 8
`define PSRW_RB_CMPV 7
`define PSRW_RB_LAT 6
`define PSRW_RB_LIVE 5
`define PSRW_RB_CMP_TOP 21
`define PSRW_KIND_CHAN 2'h0
`define PSRW_KIND_CMP 2'h1

// ****************************************************************
// interrupt bits and reset values
// ****************************************************************
`define PSRW_IRQ_TEMP 0
`define PSRW_IRQ_CMP 1
`define PSRW_RST_CTL 4'h0
`define PSRW_RST_IRQ 2'h0
`define PSRW_RST_RDATA 32'h00000000

`endif

// file: rtl/psrw_sync.v
// two-flop synchroniser for a vector of asynchronous pin levels
module psrw_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire mclk_i,
    input wire arst_n_i,
    // levels
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // the first stage feeds only the second stage
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // psrw_sync

// file: rtl/psrw_top.v
// readback word register bank for a four-channel measurement device
//
// Behaviour
// - per-channel word bit 9 shows clamp enable
// - clamp bit follows latest system or channel write
// - per-channel word bit 8 shows comparator drive
// - drive bit follows latest system or channel write
// - bit 7 high compares voltage, low current
// - bits 6/5 latched and live overtemp alarm
// - latched overtemp held until clear bit written
// - unused readback bits always read zero
// - comparator word kind bits 23:22 are 0,1
// - bits 21..14 low/high comparator pairs, ch0 first
`include "psrw_regs.vh"

module psrw_top (
    // clock and reset
    input wire mclk_i,
    input wire arst_n_i,
    // avalon-mm slave
    input wire [5:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    // analog status pins, asynchronous
    input wire overtemp_i,
    input wire [3:0] cmp_low_i,
    input wire [3:0] cmp_high_i,
    // open-drain temperature alarm pin
    output wire tmp_alarm_o,
    output wire tmp_alarm_oe_o,
    // interrupt
    output wire irq_o
);

    // ****************************************************************
    // functions
    // ****************************************************************

    // true when the address hits the word of channel ch above base
    function hit_chan;
        input [5:0] addr;
        input [5:0] base;
        input [1:0] ch;
        begin
            hit_chan = (addr == (base + {2'h0, ch, 2'h0}));
        end
    endfunction

    // per-channel readback word; upper fields live elsewhere and read zero
    function [23:0] chan_word;
        input clamp;
        input drv;
        input cmpv;
        input lat;
        input live;
        begin
            chan_word = 24'h000000;
            chan_word[`PSRW_RB_KIND_HI:`PSRW_RB_KIND_LO] = `PSRW_KIND_CHAN;
            chan_word[`PSRW_RB_CLAMP] = clamp;
            chan_word[`PSRW_RB_DRV] = drv;
            chan_word[`PSRW_RB_CMPV] = cmpv;
            chan_word[`PSRW_RB_LAT] = lat;
            chan_word[`PSRW_RB_LIVE] = live;
        end
    endfunction

    // comparator word: low before high for each channel from channel 0
    function [23:0] cmp_word;
        input [3:0] lo;
        input [3:0] hi;
        integer k;
        begin
            cmp_word = 24'h000000;
            cmp_word[`PSRW_RB_KIND_HI:`PSRW_RB_KIND_LO] = `PSRW_KIND_CMP;
            for (k = 0; k < 4; k = k + 1) begin
                cmp_word[`PSRW_RB_CMP_TOP - 2 * k] = lo[k];
                cmp_word[`PSRW_RB_CMP_TOP - 2 * k - 1] = hi[k];
            end
        end
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    wire live_s;
    wire [3:0] low_s;
    wire [3:0] high_s;

    psrw_sync #(
        .W(9)
    ) u_sync (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .async_i({overtemp_i, cmp_low_i, cmp_high_i}),
        .sync_o({live_s, low_s, high_s})
    );

    // ****************************************************************
    // bus handshake
    // ****************************************************************
    // waitrequest rests high; a request gets one wait cycle, during which
    // the read word is captured, so every field comes from the same edge
    reg wait_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;
    wire req;
    wire acc_wr;
    wire be0;

    assign req = avs_read_i | avs_write_i;
    assign acc_wr = avs_write_i & ~wait_q;
    assign be0 = avs_byteenable_i[0];

    // ****************************************************************
    // write decode
    // ****************************************************************
    wire sys_wr;
    wire stat_wr;
    wire mask_wr;
    wire [3:0] ch_wr;
    wire clr_hit;

    assign sys_wr = acc_wr & be0 & (avs_address_i == `PSRW_OFS_SYSCTL);
    assign stat_wr = acc_wr & be0 & (avs_address_i == `PSRW_OFS_IRQSTAT);
    assign mask_wr = acc_wr & be0 & (avs_address_i == `PSRW_OFS_IRQMASK);
    assign clr_hit = (|ch_wr) & avs_writedata_i[`PSRW_CB_CLR];

    // ****************************************************************
    // per-channel control state
    // ****************************************************************
    reg [3:0] clamp_q;
    reg [3:0] drv_q;
    reg [3:0] cmpv_q;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ch
            // a genvar is not a vector, so its channel number is sized here
            localparam [1:0] CH = g;

            assign ch_wr[g] = acc_wr & be0 &
                hit_chan(avs_address_i, `PSRW_OFS_CHCTL0, CH);

            // both write paths land in one flop, so the last writer wins
            always @(posedge mclk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    clamp_q[g] <= 1'b0;
                    drv_q[g] <= 1'b0;
                    cmpv_q[g] <= 1'b0;
                end else if (ch_wr[g]) begin
                    clamp_q[g] <= avs_writedata_i[`PSRW_CB_CLAMP];
                    drv_q[g] <= avs_writedata_i[`PSRW_CB_DRV];
                    cmpv_q[g] <= avs_writedata_i[`PSRW_CB_CMPV];
                end else if (sys_wr) begin
                    clamp_q[g] <= avs_writedata_i[`PSRW_CB_CLAMP];
                    drv_q[g] <= avs_writedata_i[`PSRW_CB_DRV];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // temperature alarm
    // ****************************************************************
    reg lat_q;
    reg live_prev_q;
    reg alarm_oe_q;
    reg alarm_val_q;

    // the open-drain pin only ever pulls low; its value is a flop held at zero
    // so that every output of the block leaves a register
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            alarm_val_q <= 1'b0;
        end else begin
            alarm_val_q <= 1'b0;
        end
    end

    // a still-present condition re-sets the latch even in the clear cycle
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lat_q <= 1'b0;
            live_prev_q <= 1'b0;
            alarm_oe_q <= 1'b0;
        end else begin
            lat_q <= live_s | (lat_q & ~clr_hit);
            live_prev_q <= live_s;
            alarm_oe_q <= live_s | (lat_q & ~clr_hit);
        end
    end

    // ****************************************************************
    // interrupts
    // ****************************************************************
    reg [1:0] stat_q;
    reg [1:0] mask_q;
    reg [3:0] low_prev_q;
    reg [3:0] high_prev_q;
    reg irq_q;
    wire [1:0] ev;
    wire [1:0] stat_d;

    assign ev[`PSRW_IRQ_TEMP] = live_s & ~live_prev_q;
    assign ev[`PSRW_IRQ_CMP] = |({low_s, high_s} ^ {low_prev_q, high_prev_q});
    // set beats a write-one-to-clear in the same cycle
    assign stat_d = (stat_q & ~({2{stat_wr}} & avs_writedata_i[1:0])) | ev;

    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stat_q <= `PSRW_RST_IRQ;
            mask_q <= `PSRW_RST_IRQ;
            low_prev_q <= 4'h0;
            high_prev_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            if (mask_wr) begin
                mask_q <= avs_writedata_i[1:0];
            end
            low_prev_q <= low_s;
            high_prev_q <= high_s;
            irq_q <= |(stat_q & mask_q);
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    integer i;

    always @* begin
        rdata_d = `PSRW_RST_RDATA;
        if (avs_address_i == `PSRW_OFS_SYSCTL) begin
            rdata_d = `PSRW_RST_RDATA;
        end else if (avs_address_i == `PSRW_OFS_CMPRB) begin
            rdata_d = {8'h00, cmp_word(low_s, high_s)};
        end else if (avs_address_i == `PSRW_OFS_IRQSTAT) begin
            rdata_d = {30'h00000000, stat_q};
        end else if (avs_address_i == `PSRW_OFS_IRQMASK) begin
            rdata_d = {30'h00000000, mask_q};
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (hit_chan(avs_address_i, `PSRW_OFS_CHCTL0, i[1:0])) begin
                    rdata_d = {29'h00000000, cmpv_q[i], drv_q[i], clamp_q[i]};
                end
                if (hit_chan(avs_address_i, `PSRW_OFS_CHRB0, i[1:0])) begin
                    rdata_d = {8'h00, chan_word(clamp_q[i], drv_q[i], cmpv_q[i],
                        lat_q, live_s)};
                end
            end
        end
    end

    // ****************************************************************
    // handshake registers
    // ****************************************************************
    // fixed latency: answer one edge after the request, one idle edge after
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_q <= 1'b1;
            rdata_q <= `PSRW_RST_RDATA;
        end else if (wait_q) begin
            if (req) begin
                wait_q <= 1'b0;
                rdata_q <= avs_read_i ? rdata_d : `PSRW_RST_RDATA;
            end
        end else begin
            wait_q <= 1'b1;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign tmp_alarm_o = alarm_val_q;
    assign tmp_alarm_oe_o = alarm_oe_q;
    assign irq_o = irq_q;

endmodule // psrw_top

// file: tb/psrw_pins.sv
// model of the analog front end and the pulled-up alarm line
module psrw_pins (
    // levels set by the bench
    input wire hot_i,
    input wire [3:0] lo_i,
    input wire [3:0] hi_i,
    // alarm pin from the device
    input wire tmp_alarm_o,
    input wire tmp_alarm_oe_o,
    // pins to the device
    output wire overtemp_o,
    output wire [3:0] cmp_low_o,
    output wire [3:0] cmp_high_o,
    output wire alarm_line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign overtemp_o = hot_i;
    assign cmp_low_o = lo_i;
    assign cmp_high_o = hi_i;
    // open drain: pull-up wins unless the device pulls low
    assign alarm_line_o = tmp_alarm_oe_o ? tmp_alarm_o : 1'b1;
endmodule // psrw_pins

// file: tb/psrw_chk.sv
// assertion checker for the readback register bank
`include "psrw_regs.vh"
module psrw_chk (
    // clock and reset
    input wire mclk_i,
    input wire arst_n_i,
    // bus
    input wire [5:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    // pins
    input wire overtemp_i,
    input wire [3:0] cmp_low_i,
    input wire [3:0] cmp_high_i,
    input wire tmp_alarm_o,
    input wire tmp_alarm_oe_o,
    input wire irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // pin age counter: synchroniser delay means only settled pins are compared
    wire [8:0] pins_w = {overtemp_i, cmp_low_i[0], cmp_high_i[0], cmp_low_i[1], cmp_high_i[1],
        cmp_low_i[2], cmp_high_i[2], cmp_low_i[3], cmp_high_i[3]};
    reg [8:0] prev_q;
    reg [2:0] age_q;
    wire rq_w = avs_read_i && avs_waitrequest_o;
    wire chrb_w = avs_address_i >= `PSRW_OFS_CHRB0 && avs_address_i <= 6'h20 &&
        avs_address_i[1:0] == 2'h0;
    wire calm_w = age_q >= 3'h3 && pins_w == prev_q;
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_q <= 9'h000;
            age_q <= 3'h0;
        end else begin
            prev_q <= pins_w;
            age_q <= (pins_w != prev_q) ? 3'h0 : (age_q == 3'h7) ? age_q : age_q + 3'h1;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    AST_TAKE: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
        !avs_waitrequest_o) else $error("request not answered in one cycle");
    AST_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low longer than one cycle");
    AST_TOP_ZERO: assert property (avs_readdata_o[31:24] == 8'h00)
        else $error("read data top byte not zero");
    AST_CMP_WORD: assert property (rq_w && avs_address_i == `PSRW_OFS_CMPRB |=>
        (avs_readdata_o[23:0] & 24'hC03FFF) == 24'h400000) else $error("comparator word frame");
    AST_CHAN_ZERO: assert property (rq_w && chrb_w |=>
        (avs_readdata_o[23:0] & 24'hFFFC1F) == 24'h000000) else $error("channel word spare bits");
    AST_CMP_PINS: assert property (rq_w && avs_address_i == `PSRW_OFS_CMPRB && calm_w |=>
        avs_readdata_o[21:14] == $past(pins_w[7:0])) else $error("comparator bits wrong");
    AST_LIVE: assert property (rq_w && chrb_w && calm_w |=>
        avs_readdata_o[5] == $past(overtemp_i)) else $error("live alarm bit wrong");
    AST_LATCH: assert property (rq_w && chrb_w && calm_w && overtemp_i |=>
        avs_readdata_o[6]) else $error("latched alarm bit not set");
    AST_ALARM: assert property (age_q >= 3'h5 && pins_w == prev_q && overtemp_i |->
        tmp_alarm_oe_o && !tmp_alarm_o) else $error("alarm pin not pulled");
    cover property (rq_w && avs_address_i == `PSRW_OFS_CMPRB);
    cover property ($rose(irq_o));
    cover property ($fell(tmp_alarm_oe_o));
endmodule // psrw_chk
bind psrw_top psrw_chk u_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .overtemp_i(overtemp_i), .cmp_low_i(cmp_low_i), .cmp_high_i(cmp_high_i),
    .tmp_alarm_o(tmp_alarm_o), .tmp_alarm_oe_o(tmp_alarm_oe_o), .irq_o(irq_o));

// file: tb/psrw_top_tb.sv
// self-checking bench for the readback register bank
`include "psrw_regs.vh"
module psrw_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg mclk = 1'b0, arst_n = 1'b0, rd_q = 1'b0, wr_q = 1'b0, hot = 1'b0;
    reg [5:0] addr = 6'h00;
    reg [31:0] wdata = 32'h00000000, d;
    reg [3:0] lo = 4'h0, hi = 4'h0;
    reg [7:0] p;
    wire [31:0] rdata;
    wire wreq, alo, aoe, irq, line, ot;
    wire [3:0] cl, chh;
    integer mismatches = 0, n_tests = 0, c, k;
    always #5 mclk = ~mclk;
    psrw_top u_dut (.mclk_i(mclk), .arst_n_i(arst_n), .avs_address_i(addr), .avs_read_i(rd_q),
        .avs_write_i(wr_q), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .overtemp_i(ot), .cmp_low_i(cl),
        .cmp_high_i(chh), .tmp_alarm_o(alo), .tmp_alarm_oe_o(aoe), .irq_o(irq));
    psrw_pins u_pins (.hot_i(hot), .lo_i(lo), .hi_i(hi), .tmp_alarm_o(alo),
        .tmp_alarm_oe_o(aoe), .overtemp_o(ot), .cmp_low_o(cl), .cmp_high_o(chh),
        .alarm_line_o(line));
    // ****
    // bus tasks and compare
    // ****
    task automatic wr(input [5:0] a, input [31:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr_q <= 1'b1;
        @(posedge mclk);
        while (wreq !== 1'b0) @(posedge mclk);
        wr_q <= 1'b0;
    endtask
    task automatic rd(input [5:0] a, output [31:0] v);
        @(posedge mclk);
        addr <= a;
        rd_q <= 1'b1;
        @(posedge mclk);
        while (wreq !== 1'b0) @(posedge mclk);
        v = rdata;
        rd_q <= 1'b0;
    endtask
    task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200us;
        mismatches = mismatches + 1;
        tally_and_finish;
    end
    // ****
    // scenarios
    // ****
    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        rd(`PSRW_OFS_CHRB0, d); chk("ch0 reset", d, 32'h0);
        wr(`PSRW_OFS_SYSCTL, 32'h3);
        wr(`PSRW_OFS_CHCTL0 + 6'h08, 32'h4);
        for (c = 0; c < 4; c++) begin
            rd(`PSRW_OFS_CHRB0 + 6'(4 * c), d); chk("ch word", d, c == 2 ? 32'h80 : 32'h300);
        end
        wr(`PSRW_OFS_SYSCTL, 32'h1);
        for (c = 0; c < 4; c++) begin
            rd(`PSRW_OFS_CHRB0 + 6'(4 * c), d); chk("ch word", d, c == 2 ? 32'h280 : 32'h200);
        end
        wr(`PSRW_OFS_CHRB0, 32'hFFFFFF);
        rd(`PSRW_OFS_CHRB0, d); chk("ro word", d, 32'h200);
        rd(6'h30, d); chk("unmapped", d, 32'h0);
        for (k = 0; k < 8; k++) begin
            p = 8'h01 << k;
            @(posedge mclk);
            for (c = 0; c < 4; c++) begin
                lo[c] <= p[7 - 2 * c];
                hi[c] <= p[6 - 2 * c];
            end
            repeat (4) @(posedge mclk);
            rd(`PSRW_OFS_CMPRB, d); chk("cmp word", d, 32'h400000 | (32'(p) << 14));
        end
        @(posedge mclk);
        lo <= 4'h0;
        hi <= 4'h0;
        repeat (4) @(posedge mclk);
        rd(`PSRW_OFS_IRQSTAT, d); chk("cmp irq status", d, 32'h2);
        rd(`PSRW_OFS_IRQMASK, d); chk("irq mask reset", d, 32'h0);
        wr(`PSRW_OFS_IRQSTAT, 32'h3);
        rd(`PSRW_OFS_IRQSTAT, d); chk("irq status cleared", d, 32'h0);
        @(posedge mclk);
        hot <= 1'b1;
        repeat (6) @(posedge mclk);
        rd(`PSRW_OFS_IRQSTAT, d); chk("irq status", d, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(`PSRW_OFS_IRQMASK, 32'h1);
        repeat (2) @(posedge mclk);
        chk("irq on", {31'h0, irq}, 32'h1);
        rd(`PSRW_OFS_CHRB0, d); chk("hot word", d, 32'h260);
        chk("alarm line", {31'h0, line}, 32'h0);
        wr(`PSRW_OFS_IRQSTAT, 32'h1);
        repeat (2) @(posedge mclk);
        chk("irq clear", {31'h0, irq}, 32'h0);
        @(posedge mclk);
        hot <= 1'b0;
        repeat (6) @(posedge mclk);
        rd(`PSRW_OFS_CHRB0 + 6'h04, d); chk("latched", d, 32'h240);
        chk("alarm held", {31'h0, line}, 32'h0);
        wr(`PSRW_OFS_CHCTL0 + 6'h0C, 32'h8);
        rd(`PSRW_OFS_CHRB0, d); chk("cleared", d, 32'h200);
        chk("alarm free", {31'h0, line}, 32'h1);
        tally_and_finish;
    end
endmodule // psrw_top_tb
